// ==== core/ofe_pkg.sv ====
// Overview of operation
// - Detach bit 10 cuts both photodiode pins from the amplifier; offset current only.
// - While detached, photodiode bias is switched off.
// - Short bit 5 ties both amplifier inputs to common mode while amplifier sleeps.
// - In external clock mode the clock is divided by field bits 2-0.
// - Codes 0..6 give ratios 2,8,-,12,4,1,6; host never writes 2 or 7.
// - Power-down window start count, 16 bits read/write at 0x32, resets to zero.
// - Power-down window end count, 16 bits read/write at 0x33, resets to zero.
// - Write-only 16-bit start time of the custom timing signal at 0x34.
// - Write-only 16-bit end time of the custom timing signal at 0x35.
package ofe_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0]  CTRL_OFS          = 8'h31;
    localparam logic [7:0]  SLEEP_BEGIN_OFS   = 8'h32;
    localparam logic [7:0]  SLEEP_FINISH_OFS  = 8'h33;
    localparam logic [7:0]  CUSTOM_BEGIN_OFS  = 8'h34;
    localparam logic [7:0]  CUSTOM_FINISH_OFS = 8'h35;

    localparam int          DETACH_POS        = 10;
    localparam int          SHORT_POS         = 5;
    localparam int          DIV_MSB           = 2;
    localparam int          COUNT_W           = 16;

    localparam logic [2:0]  DIV_RESET         = 3'h0;
    localparam logic [15:0] COUNT_RESET       = 16'h0;
    localparam logic [23:0] WORD_ZERO         = 24'h0;
    localparam logic [3:0]  BIT_COUNT_BYTE    = 4'h8;
    localparam logic [3:0]  BIT_COUNT_LAST    = 4'h7;
    localparam logic [1:0]  BYTE_LAST         = 2'h2;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0]  addr;
        logic [23:0] data;
    } reg_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_DEVADDR = 3'h1,
        ST_ACK     = 3'h3,
        ST_REGADDR = 3'h2,
        ST_WRITE   = 3'h6,
        ST_READ    = 3'h7,
        ST_RDACK   = 3'h5
    } link_state_t;

    // ==========================================================
    // Helpers
    // Illegal codes fall back to no division so the engine keeps running
    // ratio table
    function automatic logic [3:0] ratio_of(input logic [2:0] code);
        unique case (code)
            3'h0: ratio_of = 4'h2;
            3'h1: ratio_of = 4'h8;
            3'h3: ratio_of = 4'hc;
            3'h4: ratio_of = 4'h4;
            3'h6: ratio_of = 4'h6;
            default: ratio_of = 4'h1;
        endcase
    endfunction : ratio_of

    // Bytes go out most significant first
    function automatic logic [7:0] byte_of(input logic [23:0] word, input logic [1:0] idx);
        unique case (idx)
            2'h0: byte_of = word[23:16];
            2'h1: byte_of = word[15:8];
            default: byte_of = word[7:0];
        endcase
    endfunction : byte_of

endpackage : ofe_pkg

// ==== core/clk_ratio_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module clk_ratio_tick (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ext_mode,
    input  wire logic [2:0] code,
    output logic            tick
);
    import ofe_pkg::*;

    logic [3:0] cnt_ff;
    logic       tick_ff;
    wire  [3:0] ratio = ext_mode ? ratio_of(code) : 4'h1;
    wire        wrap  = (cnt_ff >= ratio - 4'h1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_ff  <= 4'h0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= wrap ? 4'h0 : cnt_ff + 4'h1;
            tick_ff <= wrap;
        end
    end

    assign tick = tick_ff;

    a_tick_spacing:
    assert property (@(posedge core_clk) disable iff (rst)
        tick_ff && ratio > 4'h1 && $stable(ratio) |=> !tick_ff)
        else $error("tick repeated faster than the ratio");

    a_ratio_code_two:
    assert property (@(posedge core_clk) disable iff (rst)
        ext_mode && code == 3'h0 && cnt_ff == 4'h1 |=> tick_ff && cnt_ff == 4'h0)
        else $error("divide by two did not tick on wrap");

endmodule : clk_ratio_tick
`default_nettype wire

// ==== core/i2c_reg_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_reg_port #(
    // Arbitrary neutral bus address
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic           core_clk,
    input  wire logic           rst,
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe,
    output logic                wr_valid,
    output ofe_pkg::reg_wr_t    wr_req,
    output logic [7:0]          rd_addr,
    input  wire logic [23:0]    rd_data
);
    import ofe_pkg::*;

    // ==========================================================
    // Pin synchronisers and glitch filter
    logic [2:0]  scl_sync_ff, sda_sync_ff;
    logic        scl_f_ff, sda_f_ff, scl_q_ff, sda_q_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            scl_f_ff    <= 1'b1;
            sda_f_ff    <= 1'b1;
            scl_q_ff    <= 1'b1;
            sda_q_ff    <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
            sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
            if (scl_sync_ff[1] == scl_sync_ff[2]) scl_f_ff <= scl_sync_ff[2];
            if (sda_sync_ff[1] == sda_sync_ff[2]) sda_f_ff <= sda_sync_ff[2];
            scl_q_ff    <= scl_f_ff;
            sda_q_ff    <= sda_f_ff;
        end
    end

    wire scl_rise = scl_f_ff && !scl_q_ff;
    wire scl_fall = !scl_f_ff && scl_q_ff;
    wire start    = scl_f_ff && scl_q_ff && sda_q_ff && !sda_f_ff;
    wire stop     = scl_f_ff && scl_q_ff && !sda_q_ff && sda_f_ff;

    // ==========================================================
    // Byte engine
    link_state_t state_ff;
    logic [3:0]  bit_cnt_ff;
    logic [7:0]  shift_ff, tx_ff, reg_ptr_ff;
    logic [1:0]  byte_idx_ff, ack_src_ff;
    logic        rw_ff, sda_oe_ff, wr_valid_ff;
    logic [23:0] word_ff, rd_word_ff;
    wire  [7:0]  next_rd_byte = byte_of(rd_word_ff, byte_idx_ff + 2'h1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h0;
            tx_ff <= 8'h0;
            reg_ptr_ff <= 8'h0;
            byte_idx_ff <= 2'h0;
            ack_src_ff <= 2'h0;
            rw_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            wr_valid_ff <= 1'b0;
            word_ff <= WORD_ZERO;
            rd_word_ff <= WORD_ZERO;
        end else begin
            wr_valid_ff <= 1'b0;
            if (start) begin
                state_ff <= ST_DEVADDR;
                bit_cnt_ff <= 4'h0;
                sda_oe_ff <= 1'b0;
            end else if (stop) begin
                state_ff <= ST_IDLE;
                sda_oe_ff <= 1'b0;
            end else begin
                unique case (state_ff)
                    ST_IDLE: begin
                    end
                    ST_DEVADDR, ST_REGADDR, ST_WRITE: begin
                        if (scl_rise) begin
                            shift_ff <= {shift_ff[6:0], sda_f_ff};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall && bit_cnt_ff == BIT_COUNT_BYTE) begin
                            bit_cnt_ff <= 4'h0;
                            sda_oe_ff <= 1'b1;
                            state_ff <= ST_ACK;
                            if (state_ff == ST_DEVADDR) begin
                                rw_ff <= shift_ff[0];
                                ack_src_ff <= 2'h0;
                                if (shift_ff[7:1] != DEV_ADDR) begin
                                    sda_oe_ff <= 1'b0;
                                    state_ff <= ST_IDLE;
                                end
                            end else if (state_ff == ST_REGADDR) begin
                                reg_ptr_ff <= shift_ff;
                                byte_idx_ff <= 2'h0;
                                ack_src_ff <= 2'h1;
                            end else begin
                                word_ff <= {word_ff[15:0], shift_ff};
                                ack_src_ff <= 2'h2;
                                wr_valid_ff <= (byte_idx_ff == BYTE_LAST);
                                byte_idx_ff <= (byte_idx_ff == BYTE_LAST) ? 2'h0
                                                                          : byte_idx_ff + 2'h1;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            sda_oe_ff <= 1'b0;
                            if (ack_src_ff == 2'h0 && rw_ff) begin
                                rd_word_ff <= rd_data;
                                byte_idx_ff <= 2'h0;
                                tx_ff <= byte_of(rd_data, 2'h0);
                                sda_oe_ff <= !rd_data[23];
                                state_ff <= ST_READ;
                            end else begin
                                state_ff <= (ack_src_ff == 2'h0) ? ST_REGADDR : ST_WRITE;
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            tx_ff <= {tx_ff[6:0], 1'b0};
                            sda_oe_ff <= !tx_ff[6];
                            if (bit_cnt_ff == BIT_COUNT_LAST) begin
                                sda_oe_ff <= 1'b0;
                                state_ff <= ST_RDACK;
                            end
                        end
                    end
                    ST_RDACK: begin
                        if (scl_rise && sda_f_ff) begin
                            state_ff <= ST_IDLE;
                        end else if (scl_fall) begin
                            byte_idx_ff <= (byte_idx_ff == BYTE_LAST) ? 2'h0
                                                                      : byte_idx_ff + 2'h1;
                            tx_ff <= next_rd_byte;
                            sda_oe_ff <= !next_rd_byte[7];
                            bit_cnt_ff <= 4'h0;
                            state_ff <= ST_READ;
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                        sda_oe_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-drain: the pin is only ever pulled low
    assign sda_out  = 1'b0;
    assign sda_oe   = sda_oe_ff;
    assign wr_valid = wr_valid_ff;
    assign wr_req   = '{addr: reg_ptr_ff, data: word_ff};
    assign rd_addr  = reg_ptr_ff;

endmodule : i2c_reg_port
`default_nettype wire

// ==== core/optical_frontend_ctrl_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module optical_frontend_ctrl_regs #(
    parameter logic [6:0]  DEV_ADDR   = 7'h2a,
    // Timing engine frame length in divided ticks
    parameter logic [15:0] FRAME_LEN  = 16'h9c40
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic ext_clk_mode,
    input  wire logic adc_ready_in,
    input  wire logic use_custom_ready,
    output logic      photodiode_detach,
    output logic      photodiode_bias_en,
    output logic      sense_to_common_mode,
    output logic      sleep_active,
    output logic      custom_signal,
    output logic      ready_out
);
    import ofe_pkg::*;

    // ==========================================================
    // Host link
    logic        wr_valid;
    reg_wr_t     wr_req;
    logic [7:0]  rd_addr;
    logic [23:0] rd_data;

    i2c_reg_port #(
        .DEV_ADDR (DEV_ADDR)
    ) u_link (
        .core_clk (core_clk),
        .rst      (rst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .wr_valid (wr_valid),
        .wr_req   (wr_req),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data)
    );

    // ==========================================================
    // Write decode
    wire wr_ctrl          = wr_valid && wr_req.addr == CTRL_OFS;
    wire wr_sleep_begin   = wr_valid && wr_req.addr == SLEEP_BEGIN_OFS;
    wire wr_sleep_finish  = wr_valid && wr_req.addr == SLEEP_FINISH_OFS;
    wire wr_custom_begin  = wr_valid && wr_req.addr == CUSTOM_BEGIN_OFS;
    wire wr_custom_finish = wr_valid && wr_req.addr == CUSTOM_FINISH_OFS;

    logic                detach_ff;
    logic                bias_en_ff;
    logic                input_short_ff;
    logic [2:0]          external_clock_divider_ff;
    logic [COUNT_W-1:0]  sleep_window_begin_ff;
    logic [COUNT_W-1:0]  sleep_window_finish_ff;
    logic [COUNT_W-1:0]  custom_signal_begin_ff;
    logic [COUNT_W-1:0]  custom_signal_finish_ff;

    // Reserved bits are dropped on write; the host keeps them zero.
    // reserved bits ignored
    always_ff @(posedge core_clk) begin
        if (rst) begin
            detach_ff                 <= 1'b0;
            bias_en_ff                <= 1'b1;
            input_short_ff            <= 1'b0;
            external_clock_divider_ff <= DIV_RESET;
        end else if (wr_ctrl) begin
            detach_ff                 <= wr_req.data[DETACH_POS];
            bias_en_ff                <= !wr_req.data[DETACH_POS];
            input_short_ff            <= wr_req.data[SHORT_POS];
            external_clock_divider_ff <= wr_req.data[DIV_MSB:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) sleep_window_begin_ff <= COUNT_RESET;
        else if (wr_sleep_begin) sleep_window_begin_ff <= wr_req.data[COUNT_W-1:0];
    end

    always_ff @(posedge core_clk) begin
        if (rst) sleep_window_finish_ff <= COUNT_RESET;
        else if (wr_sleep_finish) sleep_window_finish_ff <= wr_req.data[COUNT_W-1:0];
    end

    always_ff @(posedge core_clk) begin
        if (rst) custom_signal_begin_ff <= COUNT_RESET;
        else if (wr_custom_begin) custom_signal_begin_ff <= wr_req.data[COUNT_W-1:0];
    end

    always_ff @(posedge core_clk) begin
        if (rst) custom_signal_finish_ff <= COUNT_RESET;
        else if (wr_custom_finish) custom_signal_finish_ff <= wr_req.data[COUNT_W-1:0];
    end

    // ==========================================================
    // Read mux
    // Detach bit and the custom signal times are write-only and read as zero
    wire [23:0] ctrl_word  = {18'h0, input_short_ff, 2'h0, external_clock_divider_ff};
    assign rd_data = (rd_addr == CTRL_OFS)         ? ctrl_word :
                     (rd_addr == SLEEP_BEGIN_OFS)  ? {8'h0, sleep_window_begin_ff} :
                     (rd_addr == SLEEP_FINISH_OFS) ? {8'h0, sleep_window_finish_ff} :
                     WORD_ZERO;

    // ==========================================================
    // Timing engine on the divided clock
    logic               tick;
    logic [COUNT_W-1:0] frame_cnt_ff;
    logic               sleep_ff;
    logic               custom_ff;
    logic               short_ff;
    logic               ready_ff;

    clk_ratio_tick u_div (
        .core_clk (core_clk),
        .rst      (rst),
        .ext_mode (ext_clk_mode),
        .code     (external_clock_divider_ff),
        .tick     (tick)
    );

    wire frame_wrap   = frame_cnt_ff == FRAME_LEN - 16'h1;
    wire sleep_set    = frame_cnt_ff == sleep_window_begin_ff;
    wire sleep_clr    = frame_cnt_ff == sleep_window_finish_ff;
    wire custom_set   = frame_cnt_ff == custom_signal_begin_ff;
    wire custom_clr   = frame_cnt_ff == custom_signal_finish_ff;

    always_ff @(posedge core_clk) begin
        if (rst) frame_cnt_ff <= COUNT_RESET;
        else if (tick) frame_cnt_ff <= frame_wrap ? COUNT_RESET : frame_cnt_ff + 16'h1;
    end

    // Equal start and end counts mean the window never opens.
    // window edges
    always_ff @(posedge core_clk) begin
        if (rst) sleep_ff <= 1'b0;
        else if (tick && sleep_clr) sleep_ff <= 1'b0;
        else if (tick && sleep_set) sleep_ff <= 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (rst) custom_ff <= 1'b0;
        else if (tick && custom_clr) custom_ff <= 1'b0;
        else if (tick && custom_set) custom_ff <= 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (rst) short_ff <= 1'b0;
        else short_ff <= input_short_ff && sleep_ff;
    end

    // Custom signal may stand in for conversion-ready
    always_ff @(posedge core_clk) begin
        if (rst) ready_ff <= 1'b0;
        else ready_ff <= use_custom_ready ? custom_ff : adc_ready_in;
    end

    assign photodiode_detach    = detach_ff;
    assign photodiode_bias_en   = bias_en_ff;
    assign sense_to_common_mode = short_ff;
    assign sleep_active         = sleep_ff;
    assign custom_signal        = custom_ff;
    assign ready_out            = ready_ff;

    // ==========================================================
    // Assertions
    a_detach_follows_bit:
    assert property (@(posedge core_clk) disable iff (rst)
        wr_ctrl |=> detach_ff == $past(wr_req.data[DETACH_POS]))
        else $error("detach did not follow bit 10");

    a_bias_off_detach:
    assert property (@(posedge core_clk) disable iff (rst)
        bias_en_ff == !detach_ff)
        else $error("bias on while photodiode detached");

    a_short_in_sleep:
    assert property (@(posedge core_clk) disable iff (rst)
        input_short_ff && sleep_ff && $stable(input_short_ff) |=> short_ff)
        else $error("inputs not shorted during power-down");

    a_no_short_awake:
    assert property (@(posedge core_clk) disable iff (rst)
        !sleep_ff |=> !short_ff)
        else $error("inputs shorted while amplifier awake");

    a_begin_count_stored:
    assert property (@(posedge core_clk) disable iff (rst)
        wr_sleep_begin |=> sleep_window_begin_ff == $past(wr_req.data[15:0]))
        else $error("start count not stored");

    a_finish_count_stored:
    assert property (@(posedge core_clk) disable iff (rst)
        wr_sleep_finish ##1 rd_addr == SLEEP_FINISH_OFS
        |-> rd_data == {8'h0, $past(wr_req.data[15:0])})
        else $error("end count reads back wrong");

    a_write_only_zero:
    assert property (@(posedge core_clk) disable iff (rst)
        rd_addr == CUSTOM_BEGIN_OFS || rd_addr == CUSTOM_FINISH_OFS |-> rd_data == WORD_ZERO)
        else $error("write-only register read non-zero");

    a_custom_end_stored:
    assert property (@(posedge core_clk) disable iff (rst)
        wr_custom_finish |=> custom_signal_finish_ff == $past(wr_req.data[15:0]))
        else $error("custom end time not stored");

    a_window_opens:
    assert property (@(posedge core_clk) disable iff (rst)
        tick && sleep_set && !sleep_clr |=> sleep_ff)
        else $error("window did not open at start count");

    a_window_closes:
    assert property (@(posedge core_clk) disable iff (rst)
        tick && sleep_clr |=> !sleep_ff)
        else $error("window did not close at end count");

    a_window_holds:
    assert property (@(posedge core_clk) disable iff (rst)
        !tick |=> sleep_ff == $past(sleep_ff))
        else $error("window moved without a timing tick");

    a_frame_wraps:
    assert property (@(posedge core_clk) disable iff (rst)
        tick && frame_wrap |=> frame_cnt_ff == COUNT_RESET)
        else $error("timing counter did not wrap at frame end");

    a_custom_opens:
    assert property (@(posedge core_clk) disable iff (rst)
        tick && custom_set && !custom_clr |=> custom_ff)
        else $error("custom signal did not rise at start time");

    a_custom_closes:
    assert property (@(posedge core_clk) disable iff (rst)
        tick && custom_clr |=> !custom_ff)
        else $error("custom signal did not fall at end time");

    a_ready_source:
    assert property (@(posedge core_clk) disable iff (rst)
        use_custom_ready |=> ready_ff == $past(custom_ff))
        else $error("ready output not taken from custom signal");

    a_short_disabled:
    assert property (@(posedge core_clk) disable iff (rst)
        !input_short_ff |=> !short_ff)
        else $error("inputs shorted with short control clear");

    a_divider_field:
    assert property (@(posedge core_clk) disable iff (rst)
        wr_ctrl |=> external_clock_divider_ff == $past(wr_req.data[2:0]))
        else $error("divider field not stored");

endmodule : optical_frontend_ctrl_regs
`default_nettype wire

// ==== sim/i2c_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic core_clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_drv
);
    int nacks = 0;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // ==========================================
    // Bit level; data bits move SDA only well inside SCL low, frame_edge moves it with SCL high for start and stop
    task automatic half;
        repeat (8) @(posedge core_clk);
        #1;
    endtask : half
    task automatic xfer(input logic b, output logic s);
        half();
        sda_drv = b;
        half();
        scl = 1'b1;
        half();
        s = sda_wire;
        scl = 1'b0;
    endtask : xfer
    task automatic frame_edge(input logic first, input logic last);
        half();
        sda_drv = first;
        half();
        scl = 1'b1;
        half();
        sda_drv = last;
        half();
        scl = last;
    endtask : frame_edge
    task automatic wbyte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(b[i], s);
        xfer(1'b1, s);
        if (s !== 1'b0) nacks++;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(last, s);
    endtask : rbyte
    // ==========================================
    // Register transfers, three bytes per word
    task automatic write_reg(input logic [7:0] a, input logic [23:0] d);
        frame_edge(1'b1, 1'b0);
        wbyte({DEV_ADDR, 1'b0});
        wbyte(a);
        for (int k = 0; k < 3; k++) wbyte(d[23-8*k -: 8]);
        frame_edge(1'b0, 1'b1);
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [23:0] d);
        frame_edge(1'b1, 1'b0);
        wbyte({DEV_ADDR, 1'b0});
        wbyte(a);
        frame_edge(1'b1, 1'b0);
        wbyte({DEV_ADDR, 1'b1});
        for (int k = 0; k < 3; k++) rbyte(k == 2, d[23-8*k -: 8]);
        frame_edge(1'b0, 1'b1);
    endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ofe_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, ext_mode = 1'b1, adc_rdy = 1'b0, use_cr = 1'b0;
    logic scl, sda_drv, sda_oe, sda_o, detach, bias, sense, sleep, custom, ready;
    logic [23:0] rd;
    wire  logic sda_wire = sda_drv & (sda_oe ? sda_o : 1'b1);
    int errors = 0, n_checks = 0, cs, cc, cr;
    always #2.5 core_clk = ~core_clk;
    i2c_host_model host (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
    optical_frontend_ctrl_regs #(.FRAME_LEN(16'h0010)) DUT (
        .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o),
        .sda_oe(sda_oe), .ext_clk_mode(ext_mode), .adc_ready_in(adc_rdy),
        .use_custom_ready(use_cr), .photodiode_detach(detach), .photodiode_bias_en(bias),
        .sense_to_common_mode(sense), .sleep_active(sleep), .custom_signal(custom),
        .ready_out(ready));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Whole frames only, so the phase of the window does not matter
    task automatic measure(input int ratio);
        cs = 0;
        cc = 0;
        cr = 0;
        repeat (16 * ratio) @(posedge core_clk);
        repeat (32 * ratio) begin
            @(posedge core_clk);
            #1;
            cs += (sleep === 1'b1);
            cc += (sense === 1'b1);
            cr += (ready === 1'b1);
        end
    endtask : measure
    task automatic test_reset;
        chk({detach, bias, sense, sleep, custom}, 24'h8, "reset outputs");
        host.read_reg(8'h31, rd);
        chk(rd, 24'h0, "ctrl reset");
        host.read_reg(8'h32, rd);
        chk(rd, 24'h0, "begin reset");
        host.read_reg(8'h33, rd);
        chk(rd, 24'h0, "finish reset");
        $display("test_reset done");
    endtask : test_reset
    task automatic test_detach;
        host.write_reg(8'h31, 24'h000425);
        chk({detach, bias}, 24'h2, "detach on");
        host.read_reg(8'h31, rd);
        chk(rd, 24'h000025, "ctrl readback");
        host.write_reg(8'h31, 24'h000025);
        chk({detach, bias}, 24'h1, "detach off");
        $display("test_detach done");
    endtask : test_detach
    task automatic test_window;
        logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
        int ratios [6] = '{2, 8, 12, 4, 1, 6};
        host.write_reg(8'h32, 24'h000002);
        host.write_reg(8'h33, 24'h000005);
        host.read_reg(8'h32, rd);
        chk(rd, 24'h2, "begin readback");
        host.read_reg(8'h33, rd);
        chk(rd, 24'h5, "finish readback");
        // Codes 2 and 7 are never written
        for (int i = 0; i < 6; i++) begin
            host.write_reg(8'h31, {16'h0, 8'h20 | codes[i]});
            measure(ratios[i]);
            chk(cs, 6 * ratios[i], "sleep length");
            chk(cc, 6 * ratios[i], "short length");
        end
        host.write_reg(8'h31, 24'h000005);
        measure(1);
        chk(cs, 24'h6, "sleep with short off");
        chk(cc, 24'h0, "short off");
        ext_mode = 1'b0;
        host.write_reg(8'h31, 24'h000020);
        measure(1);
        chk(cs, 6, "no ext mode");
        $display("test_window done");
    endtask : test_window
    task automatic test_custom;
        host.write_reg(8'h34, 24'h000003);
        host.write_reg(8'h35, 24'h000007);
        use_cr = 1'b1;
        measure(1);
        chk(cr, 8, "custom length");
        host.read_reg(8'h34, rd);
        chk(rd, 24'h0, "begin write only");
        host.read_reg(8'h35, rd);
        chk(rd, 24'h0, "finish write only");
        host.read_reg(8'h40, rd);
        chk(rd, 24'h0, "unmapped");
        use_cr = 1'b0;
        adc_rdy = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk(ready, 1'b1, "ready passthrough");
        chk(host.nacks, 0, "acks");
        $display("test_custom done");
    endtask : test_custom
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    initial begin
        #400000;
        errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        test_reset();
        test_detach();
        test_window();
        test_custom();
        summarize();
    end
endmodule : tb
`default_nettype wire
